// ---- bench/sfc_slave_model.sv ----
/*
  Serial slave device for the master-role tests, mode 0, msb first.
  Assumes the bench resolves clock, data and select wires.
*/
module sfc_slave_model (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic selN,
  input wire logic [7:0] reply,
  output logic miso,
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] shifter = 8'h00;
  logic lastBit = 1'h0;
  initial got = 8'h00;
  ////////////////////////////////////////
  // Load at frame start so bit 7 is ready before the leading edge
  always @(negedge selN) shifter = reply;
  // Sample on leading, shift on trailing edge
  always @(posedge sclk) if (!selN) got = {got[6:0], mosi};
  always @(negedge sclk) if (!selN) shifter = {shifter[6:0], 1'h0};
  // Released line shows the inverse, never a stale bit
  always @(posedge selN) lastBit = shifter[7];
  assign miso = selN ? ~lastBit : shifter[7];
endmodule

// ---- bench/sfc_spi_fifo_control_test.sv ----
/*
  Self-checking bench of the serial port with byte queues.
  Assumes mode 0, master role except in the slave test, and the slave model on the pins.
*/
module sfc_spi_fifo_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] STA = sfc_pkg::STA_ADDR;
  localparam logic [31:0] RX = sfc_pkg::RX_ADDR;
  localparam logic [31:0] TX = sfc_pkg::TX_ADDR;
  localparam logic [31:0] DIV = sfc_pkg::DIV_ADDR;
  localparam logic [31:0] CON = sfc_pkg::CON_ADDR;
  logic clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic hreadyout, hresp, spiIrq, miso, sclkO, sclkE, mosiO, mosiE;
  logic misoO, misoE, selO, selE, sclkW, mosiW, misoW, selW, seen;
  logic mSclk = 1'h0, mMosi = 1'h1, mSel = 1'h1, slv = 1'h0;
  logic [7:0] reply = 8'h00, got;
  int fails = 0, comparisons = 0, rises = 0;
  ////////////////////////////////////////
  // Wire levels: bench master drives undriven clock, master data and select pins; slave data out comes from the slave model, pulled high in slave tests
  assign sclkW = sclkE ? sclkO : mSclk;
  assign mosiW = mosiE ? mosiO : mMosi;
  assign selW = selE ? selO : mSel;
  assign misoW = misoE ? misoO : (slv ? 1'h1 : miso);
  always #2.5 clk = ~clk;
  always @(posedge selW) rises++;
  sfc_spi_fifo_control dut (.clk(clk), .rst(rst), .clkEn(1'h1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(sfc_pkg::HSIZE_WORD),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .serialClockIn(sclkW), .serialClockOut(sclkO),
    .serialClockOe(sclkE), .masterDataOutIn(mosiW), .masterDataOutOut(mosiO),
    .masterDataOutOe(mosiE), .slaveDataOutPinIn(misoW),
    .slaveDataOutPinOut(misoO), .slaveDataOutPinOe(misoE),
    .selectLowLineInN(selW), .selectLowLineOutN(selO),
    .selectLowLineOe(selE), .spiIrq(spiIrq));
  sfc_slave_model far (.sclk(sclkW), .mosi(mosiW), .selN(selW), .reply(reply),
    .miso(miso), .got(got));
  ////////////////////////////////////////
  // One single word transfer; waits on hready, never on a fixed count
  task automatic bus(input logic w, input logic [31:0] a, d);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask
  task automatic chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [31:0] a, e);
    bus(1'h0, a, 32'h0);
    chk(r, e);
  endtask
  // Bounded wait for a frame to open and close, then the idle gap
  task automatic frame();
    int k;
    seen = 1'h0;
    for (k = 0; k < 300 && selW !== 1'h0; k++) @(posedge clk);
    if (selW === 1'h0) seen = 1'h1;
    for (k = 0; k < 3000 && selW !== 1'h1; k++) @(posedge clk);
    repeat (20) @(posedge clk);
  endtask
  // Outside master, mode 0, msb first; slow edges survive the pin synchroniser
  task automatic xfer(input logic [7:0] o, output logic [7:0] i);
    mSel <= 1'h0;
    repeat (8) @(posedge clk);
    for (int n = 7; n >= 0; n--) begin
      mMosi <= o[n];
      repeat (8) @(posedge clk);
      mSclk <= 1'h1;
      repeat (8) @(posedge clk);
      i[n] = misoW;
      mSclk <= 1'h0;
    end
    repeat (8) @(posedge clk);
    mSel <= 1'h1;
    repeat (8) @(posedge clk);
  endtask
  function automatic logic [7:0] fill(input logic zf, input logic [7:0] last);
    return zf ? 8'h00 : last;
  endfunction
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  // About 18 frames of 9 bit times; ample margin
  initial begin
    #200us;
    fails++;
    close_out();
  end
  initial begin
    logic [7:0] b, sb, sr;
    int t, k0;
    void'($urandom(41139));
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    // Reset values, divider access, unmapped word
    rd(DIV, 32'h1B);
    rd(RX, 32'h0);
    rd(CON + 32'h8, 32'h0);
    b = 8'($urandom);
    bus(1'h1, DIV, {24'h0, b});
    rd(DIV, {24'h0, b});
    bus(1'h1, DIV, 32'h7);
    $display("test registers done");
    // Loopback, then a real reply from the far side
    bus(1'h1, CON, 32'h443);
    b = 8'($urandom);
    bus(1'h1, TX, {24'h0, b});
    frame();
    rd(RX, {24'h0, b});
    bus(1'h1, CON, 32'h43);
    reply <= 8'($urandom);
    b = 8'($urandom);
    bus(1'h1, TX, {24'h0, b});
    frame();
    chk(got, b);
    rd(RX, {24'h0, reply});
    $display("test transfers done");
    // Read trigger with empty queue: last byte or zero, purge held too
    bus(1'h1, CON, 32'h3);
    bus(1'h0, RX, 32'h0);
    frame();
    chk(got, fill(1'h0, b));
    bus(1'h1, CON, 32'h2003);
    bus(1'h0, RX, 32'h0);
    frame();
    chk(got, fill(1'h0, b));
    bus(1'h1, CON, 32'h2083);
    bus(1'h1, TX, 32'h5A);
    bus(1'h0, RX, 32'h0);
    frame();
    chk(got, fill(1'h1, b));
    bus(1'h0, STA, 32'h0);
    chk(r[3:1], 3'h0);
    // Rx purge empties at once, drops bytes, read still starts a frame
    bus(1'h1, CON, 32'h1083);
    bus(1'h0, STA, 32'h0);
    chk(r[10:8], 3'h0);
    bus(1'h0, RX, 32'h0);
    frame();
    chk(seen, 1'h1);
    bus(1'h0, STA, 32'h0);
    chk({r[10:8], spiIrq}, 4'h0);
    $display("test purges done");
    // Slave role, driven then open-drain data out
    slv <= 1'h1;
    for (k0 = 0; k0 < 2; k0++) begin
      bus(1'h1, CON, k0 ? 32'h1 : 32'h201);
      b = 8'($urandom);
      sb = 8'($urandom);
      bus(1'h1, TX, {24'h0, b});
      xfer(sb, sr);
      chk(sr, b);
      rd(RX, {24'h0, sb});
    end
    slv <= 1'h0;
    $display("test slave done");
    // Tx interrupt after threshold plus one bytes, select held low
    for (t = 0; t < 4; t++) begin
      bus(1'h1, CON, {16'h0, 2'(t), 14'h0843});
      bus(1'h0, STA, 32'h0);
      k0 = rises;
      repeat (t) bus(1'h1, TX, $urandom);
      if (t > 0) frame();
      if (t > 1) chk(rises - k0, 1);
      bus(1'h0, STA, 32'h0);
      chk(r[5], 1'h0);
      bus(1'h1, TX, $urandom);
      frame();
      chk(spiIrq, 1'h1);
      bus(1'h0, STA, 32'h0);
      chk({r[5], r[0]}, 2'h3);
    end
    $display("test thresholds done");
    close_out();
  end
endmodule

// ---- rtl/sfc_fifo.sv ----
/*
  Small byte queue with flush, valid/ready on both sides and a level.
  Assumes the writer honours inReady; flush empties in one cycle.
*/
module sfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] rdPtr;
  logic [AW-1:0] wrPtr;
  logic [LW-1:0] count;

  ////////////////////////////////////////////////////////////////////////
  // Handshakes and flags
  wire doPush = inValid & inReady;
  wire doPop = outValid & outReady;
  assign inReady = (count != LW'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign level = count;

  // Pointers wrap explicitly so depth need not be a power of two
  always_ff @(posedge clk) begin
    if (rst || (clkEn && flush)) begin
      rdPtr <= '0;
      wrPtr <= '0;
      count <= '0;
    end else if (clkEn) begin
      if (doPush) begin
        mem[wrPtr] <= inData;
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + LW'(doPush) - LW'(doPop);
    end
  end

  flush_empty_a: assert property (@(posedge clk) disable iff (rst) // RL5
    clkEn && flush |=> count == '0) else $error("queue not empty after flush");
  level_bound_a: assert property (@(posedge clk) disable iff (rst)
    count <= LW'(DEPTH)) else $error("queue level above depth");

endmodule

// ---- rtl/sfc_pkg.sv ----
/*
  Shared constants and types of the serial port with byte queues:
  register byte addresses, reset values, flag positions, timing counts,
  the control-word layout and the master sequencer states.
  Assumes a 32-bit bus with one register per aligned word.
*/
package sfc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [31:0] STA_ADDR = 32'hFFFF0A00;
  localparam logic [31:0] RX_ADDR = 32'hFFFF0A04;
  localparam logic [31:0] TX_ADDR = 32'hFFFF0A08;
  localparam logic [31:0] DIV_ADDR = 32'hFFFF0A0C;
  localparam logic [31:0] CON_ADDR = 32'hFFFF0A10;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RX_RESET = 8'h00;
  localparam logic [7:0] TX_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h1B;
  localparam logic [15:0] CON_RESET = 16'h0000;
  localparam logic [7:0] ZERO_FILL = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Sticky flag positions inside the flag vector
  localparam int FLG_ISR = 0;
  localparam int FLG_UNF = 1;
  localparam int FLG_TXIRQ = 2;
  localparam int FLG_RXIRQ = 3;
  localparam int FLG_OVR = 4;
  localparam int FLG_W = 5;

  ////////////////////////////////////////////////////////////////////////
  // Sizes and serial timing
  localparam int FIFO_DEPTH = 4;
  localparam logic [8:0] DIV_ADD = 9'h001;
  localparam logic [3:0] FRAME_LAST_EDGE = 4'hF;
  localparam logic [3:0] GAP_LAST_EDGE = 4'h1;

  ////////////////////////////////////////////////////////////////////////
  // Control word, most significant field first
  typedef struct packed {
    logic [1:0] irqThresholdField;
    logic txQueuePurge;
    logic rxQueuePurge;
    logic backToBackTransfer;
    logic internalLoop;
    logic slaveOutDriveEnable;
    logic rxOverwrite;
    logic idleZeroFill;
    logic transferTriggerSelect;
    logic lsbFirst;
    logic wiredOr;
    logic clockPolarity;
    logic clockPhase;
    logic masterMode;
    logic portEnable;
  } sfc_ctrl_t;

  // Gray codes along idle, run, gap
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_GAP = 2'b11
  } sfc_state_t;

endpackage

// ---- rtl/sfc_spi_fifo_control.sv ----
/*
  Serial peripheral port with transmit and receive byte queues,
  master and slave roles, reached over an AHB-Lite slave.
  Assumes one AHB-Lite master, single word transfers, pins that
  are asynchronous to clk and an outside resolver for the enables.
*/
// Functional notes
// RL1: Tx interrupt after one to four sent bytes
// RL2: Rx interrupt at threshold, code 11 means full
// RL3: Tx purge bit empties transmit queue
// RL4: Held tx purge sends last byte or zero
// RL5: Purge empties its queue within one cycle
// RL6: Tx writes discarded while tx purge set
// RL7: Rx purge bit empties receive queue
// RL8: Rx purge drops bytes, no interrupts
// RL9: Rx purge plus read trigger starts transfer
// RL10: Back to back keeps select low while data
// RL11: Single byte mode idles one serial period
// RL12: Internal loop feeds output back to input
// RL13: Drive enable clear makes data out open-drain
// RL14: Divider register resets to 0x1B
// RL15: Receive holding register resets to zero
// RL16: Trigger select picks write or read start
// RL17: Empty queue sends zero or last byte
// RL18: Outside master frames with low select
// RL19: Overrun flag when byte meets full queue
// RL20: Serial clock from parameterised divider function
module sfc_spi_fifo_control #(
  parameter int DEPTH = sfc_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic serialClockIn,
  output logic serialClockOut,
  output logic serialClockOe,
  input wire logic masterDataOutIn,
  output logic masterDataOutOut,
  output logic masterDataOutOe,
  input wire logic slaveDataOutPinIn,
  output logic slaveDataOutPinOut,
  output logic slaveDataOutPinOe,
  input wire logic selectLowLineInN,
  output logic selectLowLineOutN,
  output logic selectLowLineOe,
  output logic spiIrq
);

  localparam int LW = $clog2(DEPTH + 1);

  sfc_pkg::sfc_ctrl_t ctrlReg;
  sfc_pkg::sfc_state_t stateReg;
  logic [31:0] addrReg;
  logic [7:0] divReg, rxHoldReg, lastTxReg, txShReg, rxShReg;
  logic [sfc_pkg::FLG_W-1:0] flagsReg;
  logic [2:0] txDoneCntReg;
  logic [8:0] halfCntReg;
  logic [3:0] edgeCntReg;
  logic wrPendReg, rdPendReg, startPendReg, outBitReg, sclkPrevReg, selPrevNReg, drvMasterReg;
  logic sclkSync, mosiSync, misoSync, selSyncN;
  logic txValid, rxValid, rxInReady;
  logic [7:0] txHead, rxHead;
  logic [LW-1:0] txLevel, rxLevel;

  function automatic logic fHead(input logic [7:0] v, input logic lsbF);
    return lsbF ? v[0] : v[7];
  endfunction

  function automatic logic [7:0] fAdv(input logic [7:0] v, input logic lsbF);
    return lsbF ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus decode; reads take one wait state so read effects see writes
  wire accept = hsel & htrans[1] & hready & (hsize == sfc_pkg::HSIZE_WORD);
  wire isSta = (addrReg == sfc_pkg::STA_ADDR);
  wire isRx = (addrReg == sfc_pkg::RX_ADDR);
  wire isTx = (addrReg == sfc_pkg::TX_ADDR);
  wire isDiv = (addrReg == sfc_pkg::DIV_ADDR);
  wire isCon = (addrReg == sfc_pkg::CON_ADDR);
  wire wrTx = wrPendReg & isTx;
  wire rdRx = rdPendReg & isRx;
  wire rdSta = rdPendReg & isSta;

  // Control field shorthands
  wire en = ctrlReg.portEnable;
  wire master = ctrlReg.masterMode;
  wire cpha = ctrlReg.clockPhase;
  wire cpol = ctrlReg.clockPolarity;
  wire lsb = ctrlReg.lsbFirst;
  wire trig = ctrlReg.transferTriggerSelect;
  wire txPurge = ctrlReg.txQueuePurge;
  wire rxPurge = ctrlReg.rxQueuePurge;

  ////////////////////////////////////////////////////////////////////////
  // Serial edge generation, shared by both roles
  wire [8:0] halfLast = 9'({1'b0, divReg}) + sfc_pkg::DIV_ADD - 9'h001; // RL20
  wire halfTick = (halfCntReg == halfLast);
  wire running = (stateReg == sfc_pkg::ST_RUN);
  wire slaveSel = en & ~master & ~selSyncN; // RL18
  wire sEdge = slaveSel & (sclkSync != sclkPrevReg);
  wire lead = master ? (running & halfTick & ~edgeCntReg[0]) : (sEdge & (sclkSync != cpol));
  wire trail = master ? (running & halfTick & edgeCntReg[0]) : (sEdge & (sclkSync == cpol));
  wire sampleEdge = cpha ? trail : lead;
  wire driveEdge = cpha ? lead : trail;
  wire frameEnd = trail & (edgeCntReg == sfc_pkg::FRAME_LAST_EDGE);
  wire selFall = slaveSel & selPrevNReg;

  // Transfer start and byte loading
  wire mStart = (stateReg == sfc_pkg::ST_IDLE) & en & master & (trig ? txValid : startPendReg); // RL16
  wire mMore = ctrlReg.backToBackTransfer & txValid;
  wire loadByte = mStart | selFall | (frameEnd & (master ? mMore : 1'b1));
  wire [7:0] loadVal = txValid ? txHead : (ctrlReg.idleZeroFill ? sfc_pkg::ZERO_FILL : lastTxReg); // RL17 RL4
  wire txPop = loadByte & txValid;
  wire inBit = ctrlReg.internalLoop ? outBitReg : (master ? misoSync : mosiSync); // RL12
  wire [7:0] rxShNext = sampleEdge ? (lsb ? {inBit, rxShReg[7:1]} : {rxShReg[6:0], inBit}) : rxShReg;
  wire outBitNext = (loadByte & ~cpha) ? fHead(loadVal, lsb) :
                    (driveEdge & ~loadByte) ? fHead(txShReg, lsb) : outBitReg;
  wire [7:0] txShNext = loadByte ? (cpha ? loadVal : fAdv(loadVal, lsb)) :
                        driveEdge ? fAdv(txShReg, lsb) : txShReg;

  ////////////////////////////////////////////////////////////////////////
  // Flag sets; a set in the clearing cycle survives
  wire rxPush = frameEnd & ~rxPurge & rxInReady; // RL8
  wire ovrSet = frameEnd & ~rxPurge & ~rxInReady; // RL19
  wire [2:0] needBytes = {1'b0, ctrlReg.irqThresholdField} + 3'h1;
  wire [2:0] rxLvl3 = 3'(rxLevel);
  wire [2:0] txLvl3 = 3'(txLevel);
  wire rxIrqSet = rxPush & ~trig & ((rxLvl3 + 3'h1) >= needBytes); // RL2
  wire txIrqSet = frameEnd & trig & ((txDoneCntReg + 3'h1) == needBytes); // RL1
  wire unfSet = loadByte & ~txValid & ~txPurge;
  wire isrSet = (ovrSet | rxIrqSet | txIrqSet | unfSet) & ~rxPurge; // RL8
  wire [sfc_pkg::FLG_W-1:0] flagSet = {ovrSet, rxIrqSet, txIrqSet, unfSet, isrSet};
  wire [sfc_pkg::FLG_W-1:0] flagsNext = flagSet | (flagsReg & ~{sfc_pkg::FLG_W{rdSta}});

  // Read data selection
  wire [7:0] rxView = rxValid ? rxHead : rxHoldReg;
  wire excess = rxLvl3 > needBytes;
  wire [15:0] staView = {4'h0, excess, rxLvl3, flagsReg[sfc_pkg::FLG_OVR], flagsReg[sfc_pkg::FLG_RXIRQ],
                         flagsReg[sfc_pkg::FLG_TXIRQ], flagsReg[sfc_pkg::FLG_UNF], txLvl3,
                         flagsReg[sfc_pkg::FLG_ISR]};
  wire [31:0] rdMux = isSta ? {16'h0000, staView} : isRx ? {24'h000000, rxView} :
                      isDiv ? {24'h000000, divReg} : isCon ? {16'h0000, ctrlReg} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and the two byte queues
  sfc_sync #(.WIDTH(4), .INIT(4'h1)) u_sync (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .din({serialClockIn, masterDataOutIn, slaveDataOutPinIn, selectLowLineInN}),
    .dout({sclkSync, mosiSync, misoSync, selSyncN})
  );

  sfc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txq (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .flush(txPurge), // RL3 RL5
    .inValid(wrTx & ~txPurge), // RL6
    .inReady(),
    .inData(hwdata[7:0]),
    .outValid(txValid),
    .outReady(txPop),
    .outData(txHead),
    .level(txLevel)
  );

  sfc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rxq (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .flush(rxPurge), // RL7 RL5
    .inValid(rxPush),
    .inReady(rxInReady),
    .inData(rxShNext),
    .outValid(rxValid),
    .outReady(rdRx),
    .outData(rxHead),
    .level(rxLevel)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus slave and software registers
  always_ff @(posedge clk) begin
    if (rst) begin
      addrReg <= 32'h00000000;
      wrPendReg <= 1'b0;
      rdPendReg <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
      ctrlReg <= sfc_pkg::CON_RESET;
      divReg <= sfc_pkg::DIV_RESET; // RL14
      rxHoldReg <= sfc_pkg::RX_RESET; // RL15
    end else if (clkEn) begin
      wrPendReg <= accept & hwrite;
      rdPendReg <= accept & ~hwrite;
      hreadyout <= ~(accept & ~hwrite);
      if (accept) begin
        addrReg <= haddr;
      end
      if (rdPendReg) begin
        hrdata <= rdMux;
      end
      if (wrPendReg && isCon) begin
        ctrlReg <= hwdata[15:0];
      end
      if (wrPendReg && isDiv) begin
        divReg <= hwdata[7:0];
      end
      if (rdRx && rxValid) begin
        rxHoldReg <= rxHead;
      end
    end
  end

  // Flags, tx byte count and a pending read-started transfer
  always_ff @(posedge clk) begin
    if (rst) begin
      flagsReg <= '0;
      spiIrq <= 1'b0;
      txDoneCntReg <= 3'h0;
      startPendReg <= 1'b0;
    end else if (clkEn) begin
      flagsReg <= flagsNext;
      spiIrq <= flagsNext[sfc_pkg::FLG_ISR];
      txDoneCntReg <= (!trig || txIrqSet) ? 3'h0 : txDoneCntReg + 3'(frameEnd);
      startPendReg <= en & master & ~trig & (rdRx | (startPendReg & ~mStart)); // RL9 RL16
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift registers, edge counter and pin drivers
  always_ff @(posedge clk) begin
    if (rst) begin
      txShReg <= 8'h00;
      rxShReg <= 8'h00;
      lastTxReg <= sfc_pkg::TX_RESET;
      outBitReg <= 1'b0;
      edgeCntReg <= 4'h0;
      sclkPrevReg <= 1'b0;
      selPrevNReg <= 1'b1;
      drvMasterReg <= 1'b0;
      slaveDataOutPinOut <= 1'b0;
      slaveDataOutPinOe <= 1'b0;
    end else if (clkEn) begin
      txShReg <= txShNext;
      rxShReg <= rxShNext;
      outBitReg <= outBitNext;
      sclkPrevReg <= sclkSync;
      selPrevNReg <= selSyncN;
      drvMasterReg <= en & master;
      if (loadByte) begin
        lastTxReg <= loadVal;
      end
      if (mStart || selFall) begin
        edgeCntReg <= 4'h0;
      end else if (lead || trail || (stateReg == sfc_pkg::ST_GAP && halfTick)) begin
        edgeCntReg <= edgeCntReg + 4'h1;
      end
      // Open-drain drives only lows, so the data bit is forced low
      slaveDataOutPinOut <= ctrlReg.slaveOutDriveEnable & outBitNext; // RL13
      slaveDataOutPinOe <= slaveSel & (ctrlReg.slaveOutDriveEnable | ~outBitNext); // RL13
    end
  end

  assign masterDataOutOut = outBitReg;
  assign masterDataOutOe = drvMasterReg;
  assign serialClockOe = drvMasterReg;
  assign selectLowLineOe = drvMasterReg;

  ////////////////////////////////////////////////////////////////////////
  // Master sequencer: select, divided clock and inter-byte gap
  always_ff @(posedge clk) begin
    if (rst) begin
      stateReg <= sfc_pkg::ST_IDLE;
      halfCntReg <= 9'h000;
      serialClockOut <= 1'b0;
      selectLowLineOutN <= 1'b1;
    end else if (clkEn) begin
      if (!(en && master)) begin
        stateReg <= sfc_pkg::ST_IDLE;
        halfCntReg <= 9'h000;
        serialClockOut <= cpol;
        selectLowLineOutN <= 1'b1;
      end else begin
        unique case (stateReg)
          sfc_pkg::ST_IDLE: begin
            halfCntReg <= 9'h000;
            serialClockOut <= cpol;
            if (mStart) begin
              stateReg <= sfc_pkg::ST_RUN;
              selectLowLineOutN <= 1'b0;
            end
          end
          sfc_pkg::ST_RUN: begin
            halfCntReg <= halfTick ? 9'h000 : halfCntReg + 9'h001;
            if (halfTick) begin
              serialClockOut <= ~serialClockOut;
            end
            if (frameEnd && !mMore) begin // RL10
              stateReg <= sfc_pkg::ST_GAP;
              selectLowLineOutN <= 1'b1;
            end
          end
          sfc_pkg::ST_GAP: begin
            halfCntReg <= halfTick ? 9'h000 : halfCntReg + 9'h001;
            if (halfTick && edgeCntReg == sfc_pkg::GAP_LAST_EDGE) begin // RL11
              stateReg <= sfc_pkg::ST_IDLE;
            end
          end
          default: begin
            stateReg <= sfc_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  tx_purge_drop_a: assert property (@(posedge clk) disable iff (rst) // RL6
    clkEn && wrTx && txPurge |=> txLevel == '0) else $error("tx write kept during purge");
  rx_purge_empty_a: assert property (@(posedge clk) disable iff (rst) // RL7
    clkEn && rxPurge |=> rxLevel == '0) else $error("rx queue filled during purge");
  rx_purge_quiet_a: assert property (@(posedge clk) disable iff (rst) // RL8
    clkEn && rxPurge && !flagsReg[sfc_pkg::FLG_ISR] |=> !spiIrq) else $error("interrupt during rx purge");
  zero_fill_a: assert property (@(posedge clk) disable iff (rst) // RL17
    clkEn && loadByte && !txValid && ctrlReg.idleZeroFill |=> lastTxReg == 8'h00)
    else $error("empty queue did not send zero");
  reset_values_a: assert property (@(posedge clk) // RL14
    rst |=> divReg == 8'h1B && rxHoldReg == 8'h00) else $error("bad register reset value");
  b2b_select_a: assert property (@(posedge clk) disable iff (rst) // RL10
    clkEn && running && frameEnd && mMore |=> running && !selectLowLineOutN)
    else $error("select released in back to back");
  gap_enter_a: assert property (@(posedge clk) disable iff (rst) // RL11
    clkEn && running && frameEnd && !mMore && en && master |=>
    stateReg == sfc_pkg::ST_GAP ##1 stateReg == sfc_pkg::ST_GAP)
    else $error("no idle gap after single byte");
  tx_irq_a: assert property (@(posedge clk) disable iff (rst) // RL1
    clkEn && txIrqSet |=> flagsReg[sfc_pkg::FLG_TXIRQ] && $past(txDoneCntReg) == needBytes - 3'h1)
    else $error("tx interrupt count wrong");
  rx_irq_a: assert property (@(posedge clk) disable iff (rst) // RL2
    clkEn && rxPush && !trig && (rxLvl3 + 3'h1) >= needBytes |=> flagsReg[sfc_pkg::FLG_RXIRQ])
    else $error("rx interrupt missed");
  overrun_a: assert property (@(posedge clk) disable iff (rst) // RL19
    clkEn && frameEnd && !rxInReady && !rxPurge |=> flagsReg[sfc_pkg::FLG_OVR] && spiIrq)
    else $error("overrun not flagged");
  open_drain_a: assert property (@(posedge clk) disable iff (rst) // RL13
    clkEn && !ctrlReg.slaveOutDriveEnable |=> !(slaveDataOutPinOe && slaveDataOutPinOut))
    else $error("data out driven high in open-drain");
  read_start_a: assert property (@(posedge clk) disable iff (rst) // RL9
    clkEn && rdRx && !trig && en && master && stateReg == sfc_pkg::ST_IDLE ##1 clkEn |=> running)
    else $error("receive read did not start transfer");

endmodule

// ---- rtl/sfc_sync.sv ----
/*
  Three-flop input synchroniser, one chain per bit.
  Assumes inputs asynchronous to clk; output moves only once
  the second and third stages agree.
*/
module sfc_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  ////////////////////////////////////////////////////////////////////////
  // One chain per bit; first stage feeds only the second
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic [2:0] stage;
    always_ff @(posedge clk) begin
      if (rst) begin
        stage <= {3{INIT[i]}};
        dout[i] <= INIT[i];
      end else if (clkEn) begin
        stage <= {stage[1:0], din[i]};
        if (stage[1] == stage[2]) begin
          dout[i] <= stage[2];
        end
      end
    end
  end

endmodule
